// >>> rtl/ppm_regs.vh
// Purpose: Register offsets, field positions and reset values of the port pin configuration block.
// Assumes: Avalon-MM word addressing, one 8-bit register per word in the low byte.
// Notes: The register at offset 0xf7 holds the pull select bits of all three ports.
`ifndef PPM_REGS_VH
`define PPM_REGS_VH
`define PPM_ADDR_W 8
`define PPM_OFF_P0_INPUT_MODE 8'h8f
`define PPM_OFF_P2_SELECT_PRIO 8'hf5
`define PPM_OFF_P2_INPUT_MODE 8'hf7
`define PPM_OFF_P0_DIRECTION 8'hfd
`define PPM_OFF_P1_DIRECTION 8'hfe
`define PPM_OFF_P2_DIRECTION_PRIO 8'hff
`define PPM_RST_BYTE 8'h00
`define PPM_RST_P2_DIRECTION 5'h00
`define PPM_MASK_P2_SELECT 8'h7f
`define PPM_MASK_P2_DIRECTION 8'hdf
`define PPM_MASK_P2_INPUT_MODE 8'he0
`define PPM_BIT_SER_SER 6
`define PPM_BIT_SER1_T3 5
`define PPM_BIT_T1_T4 4
`define PPM_BIT_SER0_T1 3
`define PPM_BIT_PULL_P0 5
`define PPM_BIT_PULL_P1 6
`define PPM_BIT_PULL_P2 7
`define PPM_P0PRI_SER0_SER1 2'h0
`define PPM_P0PRI_SER1_SER0 2'h1
`define PPM_P0PRI_T1A_SER1 2'h2
`define PPM_P0PRI_T1B_SER0 2'h3
`endif

// >>> rtl/ppm_arb2.v
// Purpose: Two-way pin owner arbiter for one shared pin group.
// Assumes: Request inputs are synchronous to clk.
// Notes: Combinational; the top registers its outputs.
`timescale 1ns/1ps
`default_nettype none
module ppm_arb2 (
  input wire req_a, // Unit A wants the pins.
  input wire req_b, // Unit B wants the pins.
  input wire pick_b, // Priority: 1 lets B win a conflict.
  output wire grant_a, // A owns the pins.
  output wire grant_b // B owns the pins.
);
  assign grant_a = req_a & ~(req_b & pick_b);
  assign grant_b = req_b & ~(req_a & ~pick_b);
endmodule
`default_nettype wire

// >>> rtl/ppm_port_pin_config_mux.v
// Purpose: Pin direction, function, input mode and peripheral priority for ports 0, 1 and 2.
// Assumes: Avalon-MM slave with waitrequest; 8-bit registers in the low byte of each word.
// Notes: Peripheral requests come from location decoding outside this block.
// How it works
// RL1 - On shared port 1 pins serial unit 0 wins when the serial-vs-serial bit is 0, unit 1 when 1.
// RL2 - On shared port 1 pins serial unit 1 wins when its timer 3 bit is 0, timer 3 when 1.
// RL3 - On shared port 1 pins timer 1 wins when its timer 4 bit is 0, timer 4 when 1.
// RL4 - On shared port 1 pins serial unit 0 wins when its timer 1 bit is 0, timer 1 when 1.
// RL5 - Select bits 2, 1, 0 give pins 4, 3, 0 of port 2 to their peripheral when 1, else GPIO.
// RL6 - Port 0 direction bits make pins outputs when 1, inputs when 0, resetting to zero.
// RL7 - Port 1 direction bits make pins outputs when 1, inputs when 0, resetting to zero.
// RL8 - Port 2 direction bits 4 to 0 make pins outputs when 1, resetting to zero.
// RL9 - The two-bit port 0 priority field picks which peripheral wins shared port 0 pins.
// RL10 - Port 0 input-mode bits choose pulled input when 0 and tristate when 1, resetting to zero.
// RL11 - One bit per port chooses pull-up when 0 and pull-down when 1 for pulled inputs.
// RL12 - The debug interface overrides port 2 function select and takes direction when it drives.
// RL13 - Unused register bits read as zero and ignore writes.
// RL14 - Software must not set up pin sharing that no priority setting resolves.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_regs.vh"
module ppm_port_pin_config_mux (
  input wire clk, // Core clock, 40 MHz.
  input wire rst_n, // Asynchronous reset, active low.
  input wire [7:0] avs_address, // Word address.
  input wire avs_read, // Read request.
  input wire avs_write, // Write request.
  input wire [31:0] avs_writedata, // Write data, low byte used.
  input wire [3:0] avs_byteenable, // Byte enables, lane 0 used.
  output reg [31:0] avs_readdata, // Read data.
  output reg avs_waitrequest, // High until the access is answered.
  output reg [1:0] avs_response, // 00 okay, 10 slave error on unmapped address.
  input wire ser0_p1_req, // Serial unit 0 placed on shared port 1 pins.
  input wire ser1_p1_req, // Serial unit 1 placed on shared port 1 pins.
  input wire tmr1_p1_req, // Timer 1 placed on shared port 1 pins.
  input wire tmr3_p1_req, // Timer 3 placed on shared port 1 pins.
  input wire tmr4_p1_req, // Timer 4 placed on shared port 1 pins.
  input wire ser0_p0_req, // Serial unit 0 placed on shared port 0 pins.
  input wire ser1_p0_req, // Serial unit 1 placed on shared port 0 pins.
  input wire tmr1a_p0_req, // Timer 1 channels 0-1 on shared port 0 pins.
  input wire tmr1b_p0_req, // Timer 1 channel 2 on shared port 0 pins.
  input wire dbg_active, // Debug interface owns pins 1 and 2 of port 2.
  input wire dbg_drive, // Debug interface drives data to the host.
  output reg [3:0] p1_ser_ser_grant_q, // Bit0 ser0, bit1 ser1 on shared port 1 pins.
  output reg [1:0] p1_ser1_t3_grant_q, // Bit0 ser1, bit1 timer 3.
  output reg [1:0] p1_t1_t4_grant_q, // Bit0 timer 1, bit1 timer 4.
  output reg [1:0] p1_ser0_t1_grant_q, // Bit0 ser0, bit1 timer 1.
  output reg [3:0] p0_grant_q, // Port 0 owner: ser0, ser1, timer1 ch0-1, timer1 ch2.
  output reg [4:0] p2_periph_q, // Port 2 pin uses peripheral function.
  output reg [4:0] p2_dir_out_q, // Port 2 pin is an output.
  output reg [7:0] p0_dir_out_q, // Port 0 pin is an output.
  output reg [7:0] p1_dir_out_q, // Port 1 pin is an output.
  output reg [7:0] p0_tristate_q, // Port 0 input tristate when 1.
  output reg [2:0] pull_down_q // Per port: 1 pull-down, 0 pull-up.
);
  reg [7:0] port0_input_mode_q;
  reg [7:0] port2_select_and_priority_q;
  reg [7:0] port2_input_mode_q;
  reg [7:0] port0_direction_q;
  reg [7:0] port1_direction_q;
  reg [7:0] port2_direction_and_priority_q;
  reg ack_q;
  reg [7:0] rd_d;
  reg hit_d;
  wire wr_go;
  wire [7:0] wb;
  wire g_ss_a, g_ss_b, g_s1t3_a, g_s1t3_b, g_t1t4_a, g_t1t4_b, g_s0t1_a, g_s0t1_b;
  wire [1:0] p0_prio;
  reg [3:0] p0_grant_d;
  reg [4:0] p2_sel_d;
  reg [4:0] p2_dir_d;

  // One wait cycle per access: request seen, answer on the next edge.
  assign wr_go = avs_write & ack_q;
  assign wb = avs_writedata[7:0];

  always @* begin
    hit_d = 1'b1;
    rd_d = 8'h00;
    case (avs_address)
      `PPM_OFF_P0_INPUT_MODE: rd_d = port0_input_mode_q;
      `PPM_OFF_P2_SELECT_PRIO: rd_d = port2_select_and_priority_q;
      `PPM_OFF_P2_INPUT_MODE: rd_d = port2_input_mode_q;
      `PPM_OFF_P0_DIRECTION: rd_d = port0_direction_q;
      `PPM_OFF_P1_DIRECTION: rd_d = port1_direction_q;
      `PPM_OFF_P2_DIRECTION_PRIO: rd_d = port2_direction_and_priority_q;
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      avs_readdata <= {24'h00_0000, rd_d}; // [RL13]
      avs_response <= hit_d ? 2'h0 : 2'h2;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_input_mode_q <= `PPM_RST_BYTE; // [RL10]
      port2_select_and_priority_q <= `PPM_RST_BYTE;
      port2_input_mode_q <= `PPM_RST_BYTE;
      port0_direction_q <= `PPM_RST_BYTE; // [RL6]
      port1_direction_q <= `PPM_RST_BYTE; // [RL7]
      port2_direction_and_priority_q <= `PPM_RST_BYTE; // [RL8]
    end else if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        `PPM_OFF_P0_INPUT_MODE: port0_input_mode_q <= wb;
        `PPM_OFF_P2_SELECT_PRIO: port2_select_and_priority_q <= wb & `PPM_MASK_P2_SELECT; // [RL13]
        `PPM_OFF_P2_INPUT_MODE: port2_input_mode_q <= wb & `PPM_MASK_P2_INPUT_MODE; // [RL13]
        `PPM_OFF_P0_DIRECTION: port0_direction_q <= wb;
        `PPM_OFF_P1_DIRECTION: port1_direction_q <= wb;
        `PPM_OFF_P2_DIRECTION_PRIO: port2_direction_and_priority_q <= wb & `PPM_MASK_P2_DIRECTION; // [RL13]
        default: port0_input_mode_q <= port0_input_mode_q;
      endcase
    end
  end

  // Conflicts that no single bit resolves are left to software to avoid. [RL14]
  ppm_arb2 u_ser_ser (
    .req_a(ser0_p1_req), .req_b(ser1_p1_req),
    .pick_b(port2_select_and_priority_q[`PPM_BIT_SER_SER]),
    .grant_a(g_ss_a), .grant_b(g_ss_b)); // [RL1]
  ppm_arb2 u_ser1_t3 (
    .req_a(ser1_p1_req), .req_b(tmr3_p1_req),
    .pick_b(port2_select_and_priority_q[`PPM_BIT_SER1_T3]),
    .grant_a(g_s1t3_a), .grant_b(g_s1t3_b)); // [RL2]
  ppm_arb2 u_t1_t4 (
    .req_a(tmr1_p1_req), .req_b(tmr4_p1_req),
    .pick_b(port2_select_and_priority_q[`PPM_BIT_T1_T4]),
    .grant_a(g_t1t4_a), .grant_b(g_t1t4_b)); // [RL3]
  ppm_arb2 u_ser0_t1 (
    .req_a(ser0_p1_req), .req_b(tmr1_p1_req),
    .pick_b(port2_select_and_priority_q[`PPM_BIT_SER0_T1]),
    .grant_a(g_s0t1_a), .grant_b(g_s0t1_b)); // [RL4]

  assign p0_prio = port2_direction_and_priority_q[7:6];

  // The unit named first by the field takes the pins when it asks; else the second; modes 2 and 3 then fall to the other serial unit.
  always @* begin
    p0_grant_d = 4'h0;
    case (p0_prio) // [RL9]
      `PPM_P0PRI_SER0_SER1: begin
        p0_grant_d[0] = ser0_p0_req;
        p0_grant_d[1] = ser1_p0_req & ~ser0_p0_req;
      end
      `PPM_P0PRI_SER1_SER0: begin
        p0_grant_d[1] = ser1_p0_req;
        p0_grant_d[0] = ser0_p0_req & ~ser1_p0_req;
      end
      `PPM_P0PRI_T1A_SER1: begin
        p0_grant_d[2] = tmr1a_p0_req;
        p0_grant_d[1] = ser1_p0_req & ~tmr1a_p0_req;
        p0_grant_d[0] = ser0_p0_req & ~ser1_p0_req & ~tmr1a_p0_req;
      end
      `PPM_P0PRI_T1B_SER0: begin
        p0_grant_d[3] = tmr1b_p0_req;
        p0_grant_d[0] = ser0_p0_req & ~tmr1b_p0_req;
        p0_grant_d[1] = ser1_p0_req & ~ser0_p0_req & ~tmr1b_p0_req;
      end
      default: p0_grant_d = 4'h0;
    endcase
  end

  // Pins 1 and 2 carry debug data and clock; debug overrides their select and, when driving, the direction of pin 1.
  always @* begin
    p2_sel_d = {port2_select_and_priority_q[2], port2_select_and_priority_q[1],
                1'b0, 1'b0, port2_select_and_priority_q[0]}; // [RL5]
    p2_dir_d = port2_direction_and_priority_q[4:0]; // [RL8]
    if (dbg_active) begin
      p2_sel_d[2:1] = 2'h3; // [RL12]
      if (dbg_drive) begin
        p2_dir_d[1] = 1'b1; // [RL12]
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_ser_ser_grant_q <= 4'h0;
      p1_ser1_t3_grant_q <= 2'h0;
      p1_t1_t4_grant_q <= 2'h0;
      p1_ser0_t1_grant_q <= 2'h0;
      p0_grant_q <= 4'h0;
      p2_periph_q <= 5'h00;
      p2_dir_out_q <= `PPM_RST_P2_DIRECTION;
      p0_dir_out_q <= `PPM_RST_BYTE;
      p1_dir_out_q <= `PPM_RST_BYTE;
      p0_tristate_q <= `PPM_RST_BYTE;
      pull_down_q <= 3'h0;
    end else begin
      p1_ser_ser_grant_q <= {2'h0, g_ss_b, g_ss_a}; // [RL1]
      p1_ser1_t3_grant_q <= {g_s1t3_b, g_s1t3_a}; // [RL2]
      p1_t1_t4_grant_q <= {g_t1t4_b, g_t1t4_a}; // [RL3]
      p1_ser0_t1_grant_q <= {g_s0t1_b, g_s0t1_a}; // [RL4]
      p0_grant_q <= p0_grant_d;
      p2_periph_q <= p2_sel_d;
      p2_dir_out_q <= p2_dir_d;
      p0_dir_out_q <= port0_direction_q; // [RL6]
      p1_dir_out_q <= port1_direction_q; // [RL7]
      p0_tristate_q <= port0_input_mode_q; // [RL10]
      pull_down_q <= {port2_input_mode_q[`PPM_BIT_PULL_P2],
                      port2_input_mode_q[`PPM_BIT_PULL_P1],
                      port2_input_mode_q[`PPM_BIT_PULL_P0]}; // [RL11]
    end
  end
endmodule
`default_nettype wire

// >>> test/ppm_periph_model.sv
// Purpose: Stands in for the serial units, timers and debug port that claim pins.
// Assumes: The bench sets the claim word on a rising edge.
// Notes: Claims are plain levels held for whole cycles.
`timescale 1ns/1ps
`default_nettype none
module ppm_periph_model (
  input wire logic [10:0] want, // Claims: port 1 units, port 0 units, debug.
  output wire logic ser0_p1_req, // Serial unit 0 on port 1.
  output wire logic ser1_p1_req, // Serial unit 1 on port 1.
  output wire logic tmr1_p1_req, // Timer 1 on port 1.
  output wire logic tmr3_p1_req, // Timer 3 on port 1.
  output wire logic tmr4_p1_req, // Timer 4 on port 1.
  output wire logic ser0_p0_req, // Serial unit 0 on port 0.
  output wire logic ser1_p0_req, // Serial unit 1 on port 0.
  output wire logic tmr1a_p0_req, // Timer 1 channels 0-1 on port 0.
  output wire logic tmr1b_p0_req, // Timer 1 channel 2 on port 0.
  output wire logic dbg_active, // Debug owns its port 2 pins.
  output wire logic dbg_drive // Debug drives data to the host.
);
  // Software keeps apart units that no priority bit ranks, so such claims are withheld.
  assign ser0_p1_req = want[0];
  assign ser1_p1_req = want[1];
  assign tmr3_p1_req = want[3] & ~want[0];
  assign tmr1_p1_req = want[2] & ~want[1] & ~tmr3_p1_req;
  assign tmr4_p1_req = want[4] & ~want[0] & ~want[1] & ~tmr3_p1_req;
  assign {dbg_drive, dbg_active, tmr1b_p0_req, tmr1a_p0_req, ser1_p0_req, ser0_p0_req} = want[10:5];
endmodule
`default_nettype wire

// >>> test/ppm_port_pin_config_mux_asserts.sv
// Purpose: Port-level checks of pin ownership and bus answer timing.
// Assumes: One clock, reset active low.
// Notes: Register contents are hidden here, so claims are judged only where the outcome does not hang on a priority bit.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_config_mux_asserts (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic avs_read, // Bus read request.
  input wire logic avs_write, // Bus write request.
  input wire logic avs_waitrequest, // Bus answer, low for one cycle.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic ser0_p1_req, // Serial unit 0 claim on port 1.
  input wire logic ser1_p1_req, // Serial unit 1 claim on port 1.
  input wire logic tmr1_p1_req, // Timer 1 claim on port 1.
  input wire logic tmr3_p1_req, // Timer 3 claim on port 1.
  input wire logic tmr4_p1_req, // Timer 4 claim on port 1.
  input wire logic tmr1a_p0_req, // Timer 1 channels 0-1 claim on port 0.
  input wire logic dbg_active, // Debug owns its port 2 pins.
  input wire logic dbg_drive, // Debug drives data out.
  input wire logic [3:0] p1_ser_ser_grant_q, // Serial pair grant.
  input wire logic [3:0] p0_grant_q, // Port 0 owner.
  input wire logic [1:0] p1_ser1_t3_grant_q, // Serial 1 and timer 3 grant.
  input wire logic [1:0] p1_t1_t4_grant_q, // Timer 1 and timer 4 grant.
  input wire logic [1:0] p1_ser0_t1_grant_q, // Serial 0 and timer 1 grant.
  input wire logic [4:0] p2_periph_q, // Port 2 peripheral use.
  input wire logic [4:0] p2_dir_out_q // Port 2 output enable.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ser_alone: assert property (ser0_p1_req && !ser1_p1_req |=> p1_ser_ser_grant_q == 4'h1)
    else $error("lone serial unit 0 lost port 1 pins");
  a_ser_single: assert property (ser0_p1_req && ser1_p1_req |=> $onehot(p1_ser_ser_grant_q))
    else $error("serial conflict not given to exactly one unit");
  a_t3_alone: assert property (tmr3_p1_req && !ser1_p1_req |=> p1_ser1_t3_grant_q == 2'h2)
    else $error("lone timer 3 lost port 1 pins");
  a_t1_alone: assert property (tmr1_p1_req && !tmr4_p1_req |=> p1_t1_t4_grant_q == 2'h1)
    else $error("lone timer 1 lost port 1 pins");
  a_s0t1_idle: assert property (!ser0_p1_req && !tmr1_p1_req |=> p1_ser0_t1_grant_q == 2'h0)
    else $error("grant without claim");
  a_t1a_gate: assert property (!tmr1a_p0_req |=> !p0_grant_q[2])
    else $error("timer 1 channels granted without claim");
  a_dbg_dir: assert property (dbg_active && dbg_drive |=> p2_dir_out_q[1])
    else $error("debug data pin not turned to output");
  a_dbg_sel: assert property (!dbg_active |=> p2_periph_q[2:1] == 2'h0)
    else $error("debug pins in peripheral use without debug");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
  a_read_high: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data high bits set");
endmodule
bind ppm_port_pin_config_mux ppm_port_pin_config_mux_asserts u_asserts (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .ser0_p1_req(ser0_p1_req), .ser1_p1_req(ser1_p1_req),
  .tmr1_p1_req(tmr1_p1_req), .tmr3_p1_req(tmr3_p1_req), .tmr4_p1_req(tmr4_p1_req),
  .tmr1a_p0_req(tmr1a_p0_req), .dbg_active(dbg_active), .dbg_drive(dbg_drive),
  .p1_ser_ser_grant_q(p1_ser_ser_grant_q), .p0_grant_q(p0_grant_q),
  .p1_ser1_t3_grant_q(p1_ser1_t3_grant_q), .p1_t1_t4_grant_q(p1_t1_t4_grant_q),
  .p1_ser0_t1_grant_q(p1_ser0_t1_grant_q), .p2_periph_q(p2_periph_q), .p2_dir_out_q(p2_dir_out_q));
`default_nettype wire

// >>> test/ppm_port_pin_config_mux_tb.sv
// Purpose: Self-checking bench for the port pin configuration block.
// Assumes: One access at a time; pins settle two edges after the last write.
// Notes: A shadow of every register predicts readback and pin outputs.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_config_mux_tb;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, rdat, seed;
  logic [3:0] avs_byteenable = 4'h1;
  logic [1:0] resp;
  logic [10:0] want = 11'h000;
  logic [7:0] rm [0:255];
  logic [7:0] adr [0:6] = '{8'h8f, 8'hf5, 8'hf7, 8'hfd, 8'hfe, 8'hff, 8'h10};
  int err_total = 0, check_count = 0, cyc = 0;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response, p1_ser1_t3_grant_q, p1_t1_t4_grant_q, p1_ser0_t1_grant_q;
  wire avs_waitrequest, s0a, s1a, t1, t3, t4, s0b, s1b, tma, tmb, dba, dbd;
  wire [3:0] p1_ser_ser_grant_q, p0_grant_q;
  wire [4:0] p2_periph_q, p2_dir_out_q;
  wire [7:0] p0_dir_out_q, p1_dir_out_q, p0_tristate_q;
  wire [2:0] pull_down_q;
  always #12.5 clk = ~clk;
  ppm_periph_model u_ppm_periph_model (.want(want), .ser0_p1_req(s0a), .ser1_p1_req(s1a),
    .tmr1_p1_req(t1), .tmr3_p1_req(t3), .tmr4_p1_req(t4), .ser0_p0_req(s0b), .ser1_p0_req(s1b),
    .tmr1a_p0_req(tma), .tmr1b_p0_req(tmb), .dbg_active(dba), .dbg_drive(dbd));
  ppm_port_pin_config_mux u_ppm_port_pin_config_mux (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .ser0_p1_req(s0a),
    .ser1_p1_req(s1a), .tmr1_p1_req(t1), .tmr3_p1_req(t3), .tmr4_p1_req(t4), .ser0_p0_req(s0b),
    .ser1_p0_req(s1b), .tmr1a_p0_req(tma), .tmr1b_p0_req(tmb), .dbg_active(dba),
    .dbg_drive(dbd), .p1_ser_ser_grant_q(p1_ser_ser_grant_q), .p1_ser1_t3_grant_q(p1_ser1_t3_grant_q),
    .p1_t1_t4_grant_q(p1_t1_t4_grant_q), .p1_ser0_t1_grant_q(p1_ser0_t1_grant_q),
    .p0_grant_q(p0_grant_q), .p2_periph_q(p2_periph_q), .p2_dir_out_q(p2_dir_out_q),
    .p0_dir_out_q(p0_dir_out_q), .p1_dir_out_q(p1_dir_out_q), .p0_tristate_q(p0_tristate_q),
    .pull_down_q(pull_down_q));
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'hf5: return 8'h7f;
      8'hff: return 8'hdf;
      8'hf7: return 8'he0;
      8'h8f, 8'hfd, 8'hfe: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [1:0] pair(input logic a, input logic b, input logic pb);
    return {b & (!a | pb), a & (!b | !pb)};
  endfunction
  function automatic logic [3:0] p0g(input logic [1:0] m, input logic [3:0] r);
    case (m)
      2'h0: return {2'b00, r[1] & !r[0], r[0]};
      2'h1: return {2'b00, r[1], r[0] & !r[1]};
      2'h2: return {1'b0, r[2], r[1] & !r[2], r[0] & !r[2] & !r[1]};
      default: return {r[3], 1'b0, r[1] & !r[3] & !r[0], r[0] & !r[3]};
    endcase
  endfunction
  // The request is held until waitrequest is seen low; that edge is the transfer.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr && be[0]) rm[a] = d & msk(a);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rdat, {24'h0, rm[a]});
    chk(resp, (msk(a) == 8'h00) ? 2'h2 : 2'h0);
  endtask
  task automatic pins;
    repeat (2) @(posedge clk);
    #1;
    chk(p1_ser_ser_grant_q, pair(s0a, s1a, rm[8'hf5][6]));
    chk(p1_ser1_t3_grant_q, pair(s1a, t3, rm[8'hf5][5]));
    chk(p1_t1_t4_grant_q, pair(t1, t4, rm[8'hf5][4]));
    chk(p1_ser0_t1_grant_q, pair(s0a, t1, rm[8'hf5][3]));
    chk(p0_grant_q, p0g(rm[8'hff][7:6], {tmb, tma, s1b, s0b}));
    chk(p2_periph_q, {rm[8'hf5][2:1], dba, dba, rm[8'hf5][0]});
    chk(p2_dir_out_q, rm[8'hff][4:0] | {3'b0, dba & dbd, 1'b0});
    chk(p0_dir_out_q, rm[8'hfd]);
    chk(p1_dir_out_q, rm[8'hfe]);
    chk(p0_tristate_q, rm[8'h8f]);
    chk(pull_down_q, rm[8'hf7][7:5]);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    seed = $urandom(17467);
    foreach (rm[i]) rm[i] = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pins;
    foreach (adr[j]) rd(adr[j]);
    foreach (adr[j]) begin
      bus(1'b1, adr[j], 8'hff, 4'h1);
      rd(adr[j]);
    end
    // Lane 0 disabled must leave the register alone.
    bus(1'b1, 8'hfd, 8'h00, 4'h0);
    rd(8'hfd);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      want <= 11'h1ff;
      bus(1'b1, 8'hff, 8'(m << 6), 4'h1);
      pins;
    end
    repeat (40) begin
      @(posedge clk);
      want <= 11'($urandom);
      for (int j = 0; j < 6; j++) bus(1'b1, adr[j], 8'($urandom), 4'h1);
      pins;
    end
    // A reset in mid-run must clear every register written above.
    @(posedge clk);
    rst_n <= 1'b0;
    want <= 11'h000;
    foreach (rm[i]) rm[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    pins;
    foreach (adr[j]) rd(adr[j]);
    give_verdict;
  end
endmodule
`default_nettype wire
